// ==== design/pcsb_regs.vh ====
`ifndef PCSB_REGS_VH
`define PCSB_REGS_VH

// Register byte offsets.
`define PCSB_OFF_MSI_CTRL   12'h000
`define PCSB_OFF_PM_CTRL    12'h004
`define PCSB_OFF_DEV_CTRL2  12'h008
`define PCSB_OFF_FLR_CTRL   12'h00C
`define PCSB_OFF_MSI_ADDR   12'h010
`define PCSB_OFF_MSI_DATA   12'h014
`define PCSB_OFF_ID_MAKER   12'h018
`define PCSB_OFF_ID_CLASS   12'h01C
`define PCSB_OFF_ID_SUBSYS  12'h020
`define PCSB_OFF_STATUS     12'h024

// Field positions.
`define PCSB_MSI_EN_BIT     0
`define PCSB_MSI_CNT_LSB    1
`define PCSB_MSI_CNT_MSB    3
`define PCSB_PM_STATE_LSB   0
`define PCSB_PM_STATE_MSB   1
`define PCSB_PME_EN_BIT     8
`define PCSB_PME_STAT_BIT   15
`define PCSB_DC2_MSB        4
`define PCSB_FLR_REQ_BIT    0
`define PCSB_FLR_RDY_BIT    1
`define PCSB_ST_LATCHED_BIT 0
`define PCSB_ST_INTX_BIT    1
`define PCSB_ST_MSI_PEND_LSB 8

// Reset values.
`define PCSB_RST_MSI_CNT    3'h0
`define PCSB_RST_PM_STATE   2'h0
`define PCSB_RST_DC2        5'h00
`define PCSB_RST_MSI_ADDR   32'h00000000
`define PCSB_RST_MSI_DATA   16'h0000

// Power state encodings.
`define PCSB_PS_D0          2'h0
`define PCSB_PS_D1          2'h1
`define PCSB_PS_D2          2'h2
`define PCSB_PS_D3          2'h3

`endif

// ==== design/pcsb_sideband.v ====
// Notes on behaviour
// RL1: Drive MSI-enabled output when software enables MSI.
// RL2: Ignore legacy interrupt input while MSI enabled.
// RL3: Output granted MSI vector count field.
// RL4: User logic raises wake input on PM events.
// RL5: Output PME enable bit, active high.
// RL6: Output two-bit device power state D0-D3.
// RL7: Identity inputs used only with load option.
// RL8: Strobe low: answer config requests with retry.
// RL9: Strobe high: answer config requests successfully.
// RL10: Strobe rising edge captures all six identities.
// RL11: Sixteen-bit maker code becomes vendor identifier.
// RL12: Sixteen-bit part code becomes device identifier.
// RL13: Eight-bit revision code becomes revision identifier.
// RL14: Twenty-four-bit category becomes class code.
// RL15: Sixteen-bit subsystem maker becomes subsystem vendor.
// RL16: Sixteen-bit subsystem part becomes subsystem device.
// RL17: Output requests user function-level reset.
// RL18: User logic raises ready for function-level reset.
// RL19: Output low five Device Control 2 bits.
// RL20: Rising request bit sends one MSI write.
// RL21: Hold reset request until ready, then reset.
`timescale 1ns/10ps
`default_nettype none
`include "pcsb_regs.vh"

module pcsb_sideband #(
  parameter       LOAD_IDS_FROM_PORTS = 1,
  parameter       MSI_VECTORS         = 8,
  // Default identity values below are arbitrary.
  parameter [15:0] DEF_MAKER          = 16'h1234,
  parameter [15:0] DEF_PART           = 16'h5678,
  parameter [7:0]  DEF_REVISION       = 8'h01,
  parameter [23:0] DEF_CATEGORY       = 24'h0B4000,
  parameter [15:0] DEF_SUB_MAKER      = 16'h1234,
  parameter [15:0] DEF_SUB_PART       = 16'h0001
) (
  // Clock and reset.
  input  wire                   sys_clk,
  input  wire                   rst_n,
  // APB slave.
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [11:0]            paddr,
  input  wire [31:0]            pwdata,
  output reg                    pready,
  output reg  [31:0]            prdata,
  output reg                    pslverr,
  // Interrupt sideband.
  input  wire                   inta_n_in,
  input  wire [MSI_VECTORS-1:0] msi_req_in,
  output reg                    msi_enable_out,
  output reg  [2:0]             msi_count_out,
  output reg                    intx_msg_valid_out,
  output reg                    intx_msg_assert_out,
  output reg                    msi_wr_valid_out,
  output reg  [31:0]            msi_wr_addr_out,
  output reg  [31:0]            msi_wr_data_out,
  input  wire                   msi_wr_ready_in,
  // Power management.
  input  wire                   pme_event_in,
  output reg                    pme_enable_out,
  output reg  [1:0]             device_power_state_out,
  // Function-level reset and Device Control 2.
  input  wire                   flr_ready_in,
  output reg                    flr_start_out,
  output reg  [4:0]             dev_ctrl2_out,
  // Identity loading.
  input  wire                   identity_latch_strobe,
  input  wire [15:0]            maker_code_in,
  input  wire [15:0]            part_code_in,
  input  wire [7:0]             revision_code_in,
  input  wire [23:0]            category_code_in,
  input  wire [15:0]            subsystem_maker_in,
  input  wire [15:0]            subsystem_part_in,
  // Configuration request answer.
  input  wire                   cfg_req_in,
  output reg                    cfg_cpl_valid_out,
  output reg                    cfg_cpl_retry_out
);

  reg                   msi_en_q;
  reg  [2:0]            msi_cnt_q;
  reg  [1:0]            pm_state_q;
  reg                   pme_en_q;
  reg                   pme_stat_q;
  reg  [4:0]            dc2_q;
  reg                   flr_req_q;
  reg  [31:0]           msi_addr_q;
  reg  [15:0]           msi_data_q;
  reg  [15:0]           id_maker_q;
  reg  [15:0]           id_part_q;
  reg  [7:0]            id_rev_q;
  reg  [23:0]           id_cat_q;
  reg  [15:0]           id_sub_maker_q;
  reg  [15:0]           id_sub_part_q;
  reg                   strobe_prev_q;
  reg                   inta_n_prev_q;
  reg  [MSI_VECTORS-1:0] msi_prev_q;
  reg  [MSI_VECTORS-1:0] msi_pend_q;
  reg  [MSI_VECTORS-1:0] msi_pend_d;
  reg  [7:0]            msi_sel;
  reg                   msi_hit;
  // Index of the vector whose write is in flight.
  reg  [7:0]            msi_cur_q;
  reg  [31:0]           rdata_d;
  reg                   rerr_d;
  integer               i;

  wire strobe_eff = (LOAD_IDS_FROM_PORTS != 0) ? identity_latch_strobe : 1'b1; // RL7
  wire strobe_rise = strobe_eff & ~strobe_prev_q;
  wire acc_wr = psel & penable & pready & pwrite;
  wire flr_done = flr_req_q & flr_ready_in;
  wire pme_clr = acc_wr & (paddr == `PCSB_OFF_PM_CTRL) & pwdata[`PCSB_PME_STAT_BIT];
  wire [MSI_VECTORS-1:0] msi_rise = msi_req_in & ~msi_prev_q;

  // Read data and error decode for the setup cycle.
  always @* begin
    rdata_d = 32'h00000000;
    rerr_d  = 1'b0;
    if (paddr == `PCSB_OFF_MSI_CTRL) begin
      rdata_d[`PCSB_MSI_EN_BIT] = msi_en_q;
      rdata_d[`PCSB_MSI_CNT_MSB:`PCSB_MSI_CNT_LSB] = msi_cnt_q;
    end else if (paddr == `PCSB_OFF_PM_CTRL) begin
      rdata_d[`PCSB_PM_STATE_MSB:`PCSB_PM_STATE_LSB] = pm_state_q;
      rdata_d[`PCSB_PME_EN_BIT] = pme_en_q;
      rdata_d[`PCSB_PME_STAT_BIT] = pme_stat_q;
    end else if (paddr == `PCSB_OFF_DEV_CTRL2) begin
      rdata_d[`PCSB_DC2_MSB:0] = dc2_q;
    end else if (paddr == `PCSB_OFF_FLR_CTRL) begin
      rdata_d[`PCSB_FLR_REQ_BIT] = flr_req_q;
      rdata_d[`PCSB_FLR_RDY_BIT] = flr_ready_in;
    end else if (paddr == `PCSB_OFF_MSI_ADDR) begin
      rdata_d = msi_addr_q;
    end else if (paddr == `PCSB_OFF_MSI_DATA) begin
      rdata_d[15:0] = msi_data_q;
    end else if (paddr == `PCSB_OFF_ID_MAKER) begin
      rdata_d = {id_part_q, id_maker_q};
    end else if (paddr == `PCSB_OFF_ID_CLASS) begin
      rdata_d = {id_cat_q, id_rev_q};
    end else if (paddr == `PCSB_OFF_ID_SUBSYS) begin
      rdata_d = {id_sub_part_q, id_sub_maker_q};
    end else if (paddr == `PCSB_OFF_STATUS) begin
      rdata_d[`PCSB_ST_LATCHED_BIT] = strobe_eff;
      rdata_d[`PCSB_ST_INTX_BIT] = intx_msg_assert_out;
      rdata_d[`PCSB_ST_MSI_PEND_LSB+MSI_VECTORS-1:`PCSB_ST_MSI_PEND_LSB] = msi_pend_q;
    end else begin
      rerr_d = 1'b1;
    end
  end

  // Lowest pending vector is sent first.
  always @* begin
    msi_sel = 8'h00;
    msi_hit = 1'b0;
    for (i = MSI_VECTORS - 1; i >= 0; i = i - 1) begin
      if (msi_pend_q[i]) begin
        msi_sel = i[7:0];
        msi_hit = 1'b1;
      end
    end
  end

  // Pending MSI vectors: a new edge wins over the clearing of its bit.
  always @* begin
    msi_pend_d = msi_pend_q;
    if (msi_wr_valid_out & msi_wr_ready_in) begin
      msi_pend_d[msi_cur_q[2:0]] = 1'b0; // RL20
    end
    if (msi_en_q) begin
      msi_pend_d = msi_pend_d | msi_rise; // RL20
    end
    if (~msi_en_q | flr_done) begin
      msi_pend_d = {MSI_VECTORS{1'b0}};
    end
  end

  // APB handshake: one wait-free access phase.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      if (psel & ~penable) begin
        prdata  <= pwrite ? 32'h00000000 : rdata_d;
        pslverr <= rerr_d;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Configuration state written by software.
  always @(posedge sys_clk) begin
    if (!rst_n || flr_done) begin
      msi_en_q   <= 1'b0;
      msi_cnt_q  <= `PCSB_RST_MSI_CNT;
      pm_state_q <= `PCSB_RST_PM_STATE;
      pme_en_q   <= 1'b0;
      dc2_q      <= `PCSB_RST_DC2;
      msi_addr_q <= `PCSB_RST_MSI_ADDR;
      msi_data_q <= `PCSB_RST_MSI_DATA;
    end else if (acc_wr) begin
      if (paddr == `PCSB_OFF_MSI_CTRL) begin
        msi_en_q  <= pwdata[`PCSB_MSI_EN_BIT];
        msi_cnt_q <= pwdata[`PCSB_MSI_CNT_MSB:`PCSB_MSI_CNT_LSB];
      end else if (paddr == `PCSB_OFF_PM_CTRL) begin
        pm_state_q <= pwdata[`PCSB_PM_STATE_MSB:`PCSB_PM_STATE_LSB];
        pme_en_q   <= pwdata[`PCSB_PME_EN_BIT];
      end else if (paddr == `PCSB_OFF_DEV_CTRL2) begin
        dc2_q <= pwdata[`PCSB_DC2_MSB:0];
      end else if (paddr == `PCSB_OFF_MSI_ADDR) begin
        msi_addr_q <= pwdata;
      end else if (paddr == `PCSB_OFF_MSI_DATA) begin
        msi_data_q <= pwdata[15:0];
      end
    end
  end

  // PME status is set by the wake input and cleared by writing one.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      pme_stat_q <= 1'b0;
    end else if (pme_event_in) begin
      pme_stat_q <= 1'b1; // RL4
    end else if (pme_clr) begin
      pme_stat_q <= 1'b0;
    end
  end

  // Function-level reset request held until user logic is ready.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      flr_req_q <= 1'b0;
    end else if (flr_done) begin
      flr_req_q <= 1'b0; // RL21
    end else if (acc_wr && (paddr == `PCSB_OFF_FLR_CTRL) && pwdata[`PCSB_FLR_REQ_BIT]) begin
      flr_req_q <= 1'b1; // RL17
    end
  end

  // Identity registers loaded on the strobe's rising edge.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      strobe_prev_q  <= 1'b0;
      id_maker_q     <= DEF_MAKER;
      id_part_q      <= DEF_PART;
      id_rev_q       <= DEF_REVISION;
      id_cat_q       <= DEF_CATEGORY;
      id_sub_maker_q <= DEF_SUB_MAKER;
      id_sub_part_q  <= DEF_SUB_PART;
    end else begin
      strobe_prev_q <= strobe_eff;
      if (strobe_rise && (LOAD_IDS_FROM_PORTS != 0)) begin // RL10
        id_maker_q     <= maker_code_in; // RL11
        id_part_q      <= part_code_in; // RL12
        id_rev_q       <= revision_code_in; // RL13
        id_cat_q       <= category_code_in; // RL14
        id_sub_maker_q <= subsystem_maker_in; // RL15
        id_sub_part_q  <= subsystem_part_in; // RL16
      end
    end
  end

  // Configuration completions, retried while the strobe is low.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_cpl_valid_out <= 1'b0;
      cfg_cpl_retry_out <= 1'b0;
    end else begin
      cfg_cpl_valid_out <= cfg_req_in;
      if (cfg_req_in) begin
        cfg_cpl_retry_out <= ~strobe_eff; // RL8 RL9
      end
    end
  end

  // Legacy interrupt messages follow the input edges.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      inta_n_prev_q       <= 1'b1;
      intx_msg_valid_out  <= 1'b0;
      intx_msg_assert_out <= 1'b0;
    end else begin
      inta_n_prev_q      <= inta_n_in;
      intx_msg_valid_out <= 1'b0;
      if (!msi_en_q && (inta_n_in != inta_n_prev_q)) begin // RL2
        intx_msg_valid_out  <= 1'b1;
        intx_msg_assert_out <= ~inta_n_in;
      end
    end
  end

  // MSI memory-write request, held until accepted or until MSI is disabled.
  // A lower vector arriving mid-flight must not clear the wrong bit.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      msi_cur_q        <= 8'h00;
      msi_prev_q       <= {MSI_VECTORS{1'b0}};
      msi_pend_q       <= {MSI_VECTORS{1'b0}};
      msi_wr_valid_out <= 1'b0;
      msi_wr_addr_out  <= 32'h00000000;
      msi_wr_data_out  <= 32'h00000000;
    end else begin
      msi_prev_q <= msi_req_in;
      msi_pend_q <= msi_pend_d;
      if (msi_wr_valid_out) begin
        if (msi_wr_ready_in || !msi_en_q) begin
          msi_wr_valid_out <= 1'b0;
        end
      end else if (msi_hit && msi_en_q && !flr_done) begin
        msi_wr_valid_out <= 1'b1; // RL20
        msi_cur_q        <= msi_sel;
        msi_wr_addr_out  <= msi_addr_q;
        msi_wr_data_out  <= {16'h0000, msi_data_q[15:8], msi_data_q[7:0] | msi_sel};
      end
    end
  end

  // Sideband outputs mirror the configuration state.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      msi_enable_out         <= 1'b0;
      msi_count_out          <= `PCSB_RST_MSI_CNT;
      pme_enable_out         <= 1'b0;
      device_power_state_out <= `PCSB_PS_D0;
      flr_start_out          <= 1'b0;
      dev_ctrl2_out          <= `PCSB_RST_DC2;
    end else begin
      msi_enable_out         <= msi_en_q; // RL1
      msi_count_out          <= msi_cnt_q; // RL3
      pme_enable_out         <= pme_en_q; // RL5
      device_power_state_out <= pm_state_q; // RL6
      flr_start_out          <= flr_req_q & ~flr_done; // RL17
      dev_ctrl2_out          <= dc2_q; // RL19
    end
  end

endmodule
`default_nettype wire

// ==== dv/pcsb_sideband_props.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "pcsb_regs.vh"
module pcsb_sideband_props (
  // Clock, reset and APB.
  input wire        sys_clk,
  input wire        rst_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  // Sideband.
  input wire        intx_msg_valid_out,
  input wire        msi_enable_out,
  input wire [2:0]  msi_count_out,
  input wire        msi_wr_valid_out,
  input wire        msi_wr_ready_in,
  input wire        pme_enable_out,
  input wire [1:0]  device_power_state_out,
  input wire        flr_ready_in,
  input wire        flr_start_out,
  input wire [4:0]  dev_ctrl2_out,
  input wire        identity_latch_strobe,
  input wire        cfg_req_in,
  input wire        cfg_cpl_valid_out,
  input wire        cfg_cpl_retry_out
);
  wire wr = psel && penable && pready && pwrite && !pslverr;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_msi_en_follow: assert property (wr && paddr == `PCSB_OFF_MSI_CTRL
    |-> ##2 msi_enable_out == $past(pwdata[0], 2)) else $error("msi enable wrong");
  a_msi_cnt_follow: assert property (wr && paddr == `PCSB_OFF_MSI_CTRL
    |-> ##2 msi_count_out == $past(pwdata[3:1], 2)) else $error("msi count wrong");
  a_pme_en_follow: assert property (wr && paddr == `PCSB_OFF_PM_CTRL
    |-> ##2 pme_enable_out == $past(pwdata[8], 2)) else $error("pme enable wrong");
  a_pm_state_follow: assert property (wr && paddr == `PCSB_OFF_PM_CTRL
    |-> ##2 device_power_state_out == $past(pwdata[1:0], 2)) else $error("power state wrong");
  a_dc2_follow: assert property (wr && paddr == `PCSB_OFF_DEV_CTRL2
    |-> ##2 dev_ctrl2_out == $past(pwdata[4:0], 2)) else $error("dc2 wrong");
  a_flr_start: assert property (wr && paddr == `PCSB_OFF_FLR_CTRL && pwdata[0]
    |-> ##[2:3] flr_start_out) else $error("flr start missing");
  a_flr_hold: assert property (flr_start_out && !flr_ready_in && !$past(flr_ready_in)
    |=> flr_start_out) else $error("flr start dropped early");
  a_intx_ignored: assert property (msi_enable_out && $past(msi_enable_out, 2)
    |-> !intx_msg_valid_out) else $error("legacy message with msi on");
  a_msi_hold: assert property (msi_wr_valid_out && !msi_wr_ready_in
    |=> msi_wr_valid_out || !msi_enable_out) else $error("msi write dropped");
  a_cfg_retry_low: assert property (cfg_req_in && !identity_latch_strobe
    |=> cfg_cpl_valid_out && cfg_cpl_retry_out) else $error("retry missing");
  a_cfg_ok_high: assert property (cfg_req_in && identity_latch_strobe
    |=> cfg_cpl_valid_out && !cfg_cpl_retry_out) else $error("success missing");
  c_msi_write: cover property (msi_wr_valid_out && msi_wr_ready_in);
  c_cfg_retry: cover property (cfg_cpl_valid_out && cfg_cpl_retry_out);
  c_flr_done: cover property (flr_start_out && flr_ready_in);
endmodule
`default_nettype wire

// ==== dv/pcsb_sideband_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "pcsb_regs.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module pcsb_sideband_tb_top;
  logic sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic inta_n_in = 1'b1, pme_event_in = 1'b0, identity_latch_strobe = 1'b0, cfg_req_in = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  msi_req_in = 8'h00, revision_code_in = 8'h00;
  logic [2:0]  dly = 3'h0;
  logic [15:0] maker_code_in = 16'h0, part_code_in = 16'h0;
  logic [15:0] subsystem_maker_in = 16'h0, subsystem_part_in = 16'h0;
  logic [23:0] category_code_in = 24'h0;
  logic pready, pslverr, msi_enable_out, intx_msg_valid_out, intx_msg_assert_out;
  logic msi_wr_valid_out, msi_wr_ready_in, pme_enable_out, flr_ready_in, flr_start_out;
  logic cfg_cpl_valid_out, cfg_cpl_retry_out, e;
  logic [31:0] prdata, msi_wr_addr_out, msi_wr_data_out, r;
  logic [2:0]  msi_count_out;
  logic [1:0]  device_power_state_out;
  logic [4:0]  dev_ctrl2_out;
  logic [63:0] acc[$];
  int          n_checks, miscompares, nintx, k;
  pcsb_sideband pcsb_sideband_inst (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .inta_n_in, .msi_req_in, .msi_enable_out, .msi_count_out,
    .intx_msg_valid_out, .intx_msg_assert_out, .msi_wr_valid_out, .msi_wr_addr_out,
    .msi_wr_data_out, .msi_wr_ready_in, .pme_event_in, .pme_enable_out, .device_power_state_out,
    .flr_ready_in, .flr_start_out, .dev_ctrl2_out, .identity_latch_strobe, .maker_code_in,
    .part_code_in, .revision_code_in, .category_code_in, .subsystem_maker_in, .subsystem_part_in,
    .cfg_req_in, .cfg_cpl_valid_out, .cfg_cpl_retry_out);
  pcsb_user_model pcsb_user_model_inst (.sys_clk, .rst_n, .dly, .msi_wr_valid_out,
    .flr_start_out, .msi_wr_ready_in, .flr_ready_in);
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (rst_n && msi_wr_valid_out && msi_wr_ready_in) acc.push_back({msi_wr_addr_out, msi_wr_data_out});
    if (rst_n && intx_msg_valid_out) nintx++;
  end
  task complete_run;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task stall;
    miscompares++;
    complete_run();
  endtask
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) stall();
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task cfg(input logic exp);
    @(posedge sys_clk);
    cfg_req_in <= 1'b1;
    @(posedge sys_clk);
    cfg_req_in <= 1'b0;
    @(posedge sys_clk);
    `CHK({cfg_cpl_valid_out, cfg_cpl_retry_out}, {1'b1, exp})
  endtask
  task inta(input int expn);
    k = nintx;
    @(posedge sys_clk);
    inta_n_in <= 1'b0;
    tick(4);
    `CHK(intx_msg_assert_out, expn != 0)
    inta_n_in <= 1'b1;
    tick(4);
    `CHK(intx_msg_assert_out, 1'b0)
    `CHK(nintx - k, expn)
  endtask
  task t_ids;
    apb(1'b0, `PCSB_OFF_ID_MAKER, 32'h0);
    `CHK(r, 32'h56781234)
    apb(1'b0, 12'h0FC, 32'h0);
    `CHK({e, r}, 33'h100000000)
    cfg(1'b1);
    maker_code_in <= 16'hA1B2;
    part_code_in <= 16'hC3D4;
    revision_code_in <= 8'h5E;
    category_code_in <= 24'h6F7081;
    subsystem_maker_in <= 16'h92A3;
    subsystem_part_in <= 16'hB4C5;
    @(posedge sys_clk);
    identity_latch_strobe <= 1'b1;
    @(posedge sys_clk);
    maker_code_in <= 16'hFFFF;
    cfg(1'b0);
    apb(1'b0, `PCSB_OFF_ID_MAKER, 32'h0);
    `CHK(r, 32'hC3D4A1B2)
    apb(1'b0, `PCSB_OFF_ID_CLASS, 32'h0);
    `CHK(r, 32'h6F70815E)
    apb(1'b0, `PCSB_OFF_ID_SUBSYS, 32'h0);
    `CHK(r, 32'hB4C592A3)
    identity_latch_strobe <= 1'b0;
    cfg(1'b1);
  endtask
  task t_pm;
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, `PCSB_OFF_PM_CTRL, {23'h0, s[0], 6'h0, s[1:0]});
      tick(2);
      `CHK({pme_enable_out, device_power_state_out}, {s[0], s[1:0]})
    end
    pme_event_in <= 1'b1;
    @(posedge sys_clk);
    pme_event_in <= 1'b0;
    apb(1'b0, `PCSB_OFF_PM_CTRL, 32'h0);
    `CHK(r[15], 1'b1)
    apb(1'b1, `PCSB_OFF_PM_CTRL, 32'h8000);
    apb(1'b0, `PCSB_OFF_PM_CTRL, 32'h0);
    `CHK(r[15], 1'b0)
  endtask
  task t_msi;
    apb(1'b1, `PCSB_OFF_MSI_ADDR, 32'hFEE01000);
    apb(1'b1, `PCSB_OFF_MSI_DATA, 32'h00004A20);
    apb(1'b1, `PCSB_OFF_MSI_CTRL, 32'h0000000B);
    tick(2);
    `CHK({msi_enable_out, msi_count_out}, 4'hD)
    inta(0);
    dly <= 3'h3;
    msi_req_in <= 8'h0A;
    for (int n = 0; n < 40 && acc.size() < 2; n++) @(posedge sys_clk);
    if (acc.size() < 2) stall();
    `CHK(acc[0], 64'hFEE0100000004A21)
    `CHK(acc[1], 64'hFEE0100000004A23)
    msi_req_in <= 8'h00;
    tick(2);
    msi_req_in <= 8'h08;
    tick(2);
    msi_req_in <= 8'h09;
    for (int n = 0; n < 40 && acc.size() < 4; n++) @(posedge sys_clk);
    if (acc.size() < 4) stall();
    `CHK(acc[2], 64'hFEE0100000004A23)
    `CHK(acc[3], 64'hFEE0100000004A20)
    msi_req_in <= 8'h00;
    apb(1'b1, `PCSB_OFF_MSI_CTRL, 32'h0);
    tick(2);
    inta(2);
  endtask
  task t_flr;
    apb(1'b1, `PCSB_OFF_DEV_CTRL2, 32'h15);
    tick(2);
    `CHK(dev_ctrl2_out, 5'h15)
    dly <= 3'h5;
    apb(1'b1, `PCSB_OFF_MSI_CTRL, 32'h1);
    apb(1'b1, `PCSB_OFF_FLR_CTRL, 32'h1);
    for (k = 0; k < 20 && flr_start_out !== 1'b1; k++) @(posedge sys_clk);
    if (k == 20) stall();
    `CHK(flr_start_out, 1'b1)
    for (k = 0; k < 20 && flr_start_out === 1'b1; k++) @(posedge sys_clk);
    if (k == 20) stall();
    `CHK(k > 5, 1'b1)
    tick(2);
    `CHK({msi_enable_out, dev_ctrl2_out}, 6'h00)
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_ids();
    t_pm();
    t_msi();
    t_flr();
    complete_run();
  end
endmodule
bind pcsb_sideband pcsb_sideband_props pcsb_sideband_props_inst (.sys_clk, .rst_n, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .intx_msg_valid_out, .msi_enable_out,
  .msi_count_out, .msi_wr_valid_out, .msi_wr_ready_in, .pme_enable_out, .device_power_state_out,
  .flr_ready_in, .flr_start_out, .dev_ctrl2_out, .identity_latch_strobe, .cfg_req_in,
  .cfg_cpl_valid_out, .cfg_cpl_retry_out);
`default_nettype wire

// ==== dv/pcsb_user_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module pcsb_user_model (
  // Clock, reset and answer delay.
  input  wire       sys_clk,
  input  wire       rst_n,
  input  wire [2:0] dly,
  // Handshakes.
  input  wire       msi_wr_valid_out,
  input  wire       flr_start_out,
  output wire       msi_wr_ready_in,
  output wire       flr_ready_in
);
  reg [2:0] mcnt_q;
  reg [2:0] fcnt_q;
  assign msi_wr_ready_in = msi_wr_valid_out && mcnt_q == dly;
  assign flr_ready_in    = flr_start_out && fcnt_q == dly;
  always @(posedge sys_clk) begin
    if (!rst_n || !msi_wr_valid_out || msi_wr_ready_in) mcnt_q <= 3'h0;
    else mcnt_q <= mcnt_q + 3'h1;
    if (!rst_n || !flr_start_out || flr_ready_in) fcnt_q <= 3'h0;
    else fcnt_q <= fcnt_q + 3'h1;
  end
endmodule
`default_nettype wire
